// *** bench/ccr_host_model.sv ***
// Host model that drives frames on the serial configuration port.
`timescale 1ns/1ps
module ccr_host_model (
   // Clock
   input  wire logic CLK,
   // Serial port
   output logic      SCLK,
   output logic      SDI,
   output logic      CSN,
   input  wire logic SDO,
   input  wire logic SDO_OE
);
   // Eight cycles per half period leaves margin over the three-stage pin filter.
   localparam int HALF = 8;
   initial begin
      SCLK = 1'b0;
      SDI = 1'b0;
      CSN = 1'b1;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge CLK);
   endtask
   // A frame cut short after n rises must leave every register untouched.
   task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d, input int n,
                        output logic [7:0] q, output logic oe);
      logic [23:0] w;
      w = {rd, a, d};
      q = 8'h00;
      oe = 1'b1;
      CSN = 1'b0;
      gap(HALF);
      for (int i = 23; i >= 24 - n; i--) begin
         SDI = w[i];
         gap(HALF);
         SCLK = 1'b1;
         if (i < 8) begin
            q = {q[6:0], SDO};
            oe = oe & SDO_OE;
         end
         gap(HALF);
         SCLK = 1'b0;
      end
      // A released data line gets no pull, so it shows the inverse of its last level.
      SDI = ~SDI;
      gap(HALF);
      CSN = 1'b1;
      gap(HALF);
   endtask
endmodule

// *** bench/ccr_top_tb_top.sv ***
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
module ccr_top_tb_top;
   logic        CLK, RESETN, SCLK, SDI, CSN, SDO, SDO_OE, PLL_ENABLE;
   logic [23:0] pos;
   logic [3:0]  align;
   logic [15:0] fs;
   logic [7:0]  pm1, pm2, pm3, pm4, div;
   logic        pm_res, ts_rx, ts_pecl, refo;
   int          failures, compares, cycles;
   logic [7:0]  q, code;
   logic        o;
   ccr_host_model host_u (.CLK(CLK), .SCLK(SCLK), .SDI(SDI), .CSN(CSN), .SDO(SDO), .SDO_OE(SDO_OE));
   ccr_top dut_u (.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .SDI(SDI), .CSN(CSN), .SDO(SDO),
      .SDO_OE(SDO_OE), .REFERENCE_EDGE_POSITION(pos), .PLL_ENABLE(PLL_ENABLE),
      .ALIGNMENT_DELAY_SELECT(align), .FULL_SCALE_CODE(fs), .POWER_MODE_CODE(pm1),
      .POWER_MODE_SECOND(pm2), .POWER_MODE_THIRD(pm3), .POWER_MODE_FOURTH(pm4),
      .POWER_MODE_RESERVED(pm_res), .TIMESTAMP_RECEIVER_ENABLE(ts_rx), .TIMESTAMP_PECL_MODE(ts_pecl),
      .PLL_FEEDBACK_DIVIDER(div), .REFERENCE_CLOCK_OUTPUT_ACTIVE(refo));
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // ------------------------------------------------------------
   // Checking and access tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host_u.frame(1'b0, a, d, 24, q, o);
   endtask
   // The read byte, the output enable while shifting and its release afterwards are all checked.
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      host_u.frame(1'b1, a, 8'h00, 24, q, o);
      chk({8'h00, q}, {8'h00, e});
      chk({14'h0000, o, SDO_OE}, 16'h0002);
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         $display("FAIL at %0t: run did not finish", $time);
         report_and_stop;
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      RESETN = 1'b0;
      PLL_ENABLE = 1'b1;
      pos = 24'h5A3C96;
      failures = 0;
      compares = 0;
      cycles = 0;
      repeat (16) @(negedge CLK);
      RESETN = 1'b1;
      host_u.gap(8);
      chk(fs, 16'hA000);
      chk({pm1, pm4}, 16'h4B4B);
      chk({9'h000, ts_pecl, ts_rx, refo, align}, 16'h0010);
      rd(15'h0030, 8'h00);
      rd(15'h0031, 8'hA0);
      rd(15'h0037, 8'h4B);
      rd(15'h003C, 8'h01);
      rd(15'h002C, 8'h96);
      rd(15'h002D, 8'h3C);
      rd(15'h002E, 8'h5A);
      wr(15'h002E, 8'hFF);
      pos = 24'hC3A5F0;
      rd(15'h002E, 8'hC3);
      // The delay select is written with 0x0B, checked at its output and read back.
      wr(15'h0029, 8'h0B);
      chk({12'h000, align}, 16'h000B);
      rd(15'h0029, 8'h0B);
      wr(15'h0030, 8'hFF);
      wr(15'h0031, 8'hFF);
      chk(fs, 16'hFFFF);
      wr(15'h0031, 8'h20);
      wr(15'h0030, 8'h00);
      chk(fs, 16'h2000);
      // Calibration and link enables sit outside this block and are taken as cleared here.
      for (int k = 0; k < 3; k++) begin
         code = (k == 0) ? 8'h46 : (k == 1) ? 8'h4B : 8'h55;
         for (int r = 0; r < 4; r++) begin
            wr(15'h0037 + 15'(r), code);
         end
         chk({pm1, pm2}, {code, code});
         chk({pm3, pm4}, {code, code});
         chk({15'h0000, pm_res}, {15'h0000, k == 2});
         for (int r = 0; r < 4; r++) begin
            rd(15'h0037 + 15'(r), code);
         end
      end
      // A calibration would follow each mode change; it lies outside this block.
      for (int r = 0; r < 4; r++) begin
         wr(15'h0037 + 15'(r), 8'h4B);
      end
      chk({15'h0000, pm_res}, 16'h0000);
      for (int v = 0; v < 4; v++) begin
         wr(15'h003B, 8'(v));
         chk({14'h0000, ts_pecl, ts_rx}, 16'(v));
         rd(15'h003B, 8'(v));
      end
      PLL_ENABLE = 1'b0;
      host_u.gap(2);
      chk({15'h0000, refo}, 16'h0000);
      PLL_ENABLE = 1'b1;
      host_u.gap(2);
      chk({15'h0000, refo}, 16'h0001);
      wr(15'h003C, 8'h00);
      chk({15'h0000, refo}, 16'h0000);
      wr(15'h003C, 8'h01);
      chk({15'h0000, refo}, 16'h0001);
      wr(15'h003D, 8'h0A);
      chk({8'h00, div}, 16'h000A);
      rd(15'h003D, 8'h0A);
      rd(15'h0050, 8'h00);
      host_u.frame(1'b0, 15'h003D, 8'h05, 12, q, o);
      chk({8'h00, div}, 16'h000A);
      RESETN = 1'b0;
      host_u.gap(2);
      chk({fs[15:8], pm1}, 16'hA04B);
      chk({10'h000, align, refo, ts_rx}, 16'h0000);
      RESETN = 1'b1;
      host_u.gap(8);
      chk({15'h0000, refo}, 16'h0001);
      report_and_stop;
   end
endmodule

// *** src/ccr_pkg.sv ***
// Package of register offsets, reset values and state layout for the converter configuration registers.
package ccr_pkg;

   // ------------------------------------------------------------
   // Serial frame layout
   // ------------------------------------------------------------
   localparam int             FRAME_BITS  = 24;
   localparam int             ADDR_W      = 15;
   localparam logic [4:0]     CNT_ADDR    = 5'h0F;
   localparam logic [4:0]     CNT_DATA0   = 5'h10;
   localparam logic [4:0]     CNT_LAST    = 5'h17;
   localparam logic [4:0]     CNT_DONE    = 5'h18;
   localparam int             RW_BIT      = 23;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [14:0]    ADR_ALIGN_SEL = 15'h0029;
   localparam logic [14:0]    ADR_POS_LO    = 15'h002C;
   localparam logic [14:0]    ADR_POS_MID   = 15'h002D;
   localparam logic [14:0]    ADR_POS_HI    = 15'h002E;
   localparam logic [14:0]    ADR_FS_LO     = 15'h0030;
   localparam logic [14:0]    ADR_FS_HI     = 15'h0031;
   localparam logic [14:0]    ADR_PM1       = 15'h0037;
   localparam logic [14:0]    ADR_PM2       = 15'h0038;
   localparam logic [14:0]    ADR_PM3       = 15'h0039;
   localparam logic [14:0]    ADR_PM4       = 15'h003A;
   localparam logic [14:0]    ADR_TS_CTRL   = 15'h003B;
   localparam logic [14:0]    ADR_REFO_CTRL = 15'h003C;
   localparam logic [14:0]    ADR_PLL_DIV   = 15'h003D;

   // ------------------------------------------------------------
   // Reset values, field positions and codes
   // ------------------------------------------------------------
   localparam logic [15:0]    RST_FS        = 16'hA000;
   localparam logic [7:0]     RST_PM        = 8'h4B;
   localparam logic [7:0]     PM_LOW_POWER  = 8'h46;
   localparam logic [7:0]     PM_HIGH_PERF  = 8'h4B;
   localparam logic [1:0]     RST_TS        = 2'h0;
   localparam logic           RST_REFO_EN   = 1'b1;
   localparam logic [7:0]     RST_PLL_DIV   = 8'h00;
   localparam logic [3:0]     RST_ALIGN     = 4'h0;
   localparam int             TS_RECV_BIT   = 0;
   localparam int             TS_PECL_BIT   = 1;
   localparam int             REFO_EN_BIT   = 0;

   // ------------------------------------------------------------
   // Complete state of the register bank
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  sclk_s;
      logic [2:0]  sdi_s;
      logic [2:0]  csn_s;
      logic        sclk_f;
      logic        sdi_f;
      logic        csn_f;
      logic [4:0]  cnt;
      logic [23:0] shin;
      logic [7:0]  sdout;
      logic        reading;
      logic        sdo;
      logic        sdo_oe;
      logic [3:0]  align_sel;
      logic [15:0] fs_code;
      logic [7:0]  pm1;
      logic [7:0]  pm2;
      logic [7:0]  pm3;
      logic [7:0]  pm4;
      logic [1:0]  ts_ctrl;
      logic        refo_en;
      logic [7:0]  pll_div;
      logic        refclk_active;
      logic        pm_reserved;
   } ccr_state_t;

endpackage

// *** src/ccr_top.sv ***
// Configuration and status register bank with its serial configuration port.
`timescale 1ns/1ps
module ccr_top (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RESETN,
   // Serial configuration port
   input  wire logic        SCLK,
   input  wire logic        SDI,
   input  wire logic        CSN,
   output logic             SDO,
   output logic             SDO_OE,
   // Status and enables from the converter core
   input  wire logic [23:0] REFERENCE_EDGE_POSITION,
   input  wire logic        PLL_ENABLE,
   // Configuration outputs
   output logic [3:0]       ALIGNMENT_DELAY_SELECT,
   output logic [15:0]      FULL_SCALE_CODE,
   output logic [7:0]       POWER_MODE_CODE,
   output logic [7:0]       POWER_MODE_SECOND,
   output logic [7:0]       POWER_MODE_THIRD,
   output logic [7:0]       POWER_MODE_FOURTH,
   output logic             POWER_MODE_RESERVED,
   output logic             TIMESTAMP_RECEIVER_ENABLE,
   output logic             TIMESTAMP_PECL_MODE,
   output logic [7:0]       PLL_FEEDBACK_DIVIDER,
   output logic             REFERENCE_CLOCK_OUTPUT_ACTIVE
);

   // ------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------
   function automatic logic [7:0] ccr_read(input logic [14:0] adr, input ccr_pkg::ccr_state_t s,
                                           input logic [23:0] pos);
      logic [7:0] v;
      v = 8'h00;
      unique case (adr)
         ccr_pkg::ADR_ALIGN_SEL: v = {4'h0, s.align_sel};
         ccr_pkg::ADR_POS_LO:    v = pos[7:0];
         ccr_pkg::ADR_POS_MID:   v = pos[15:8];
         ccr_pkg::ADR_POS_HI:    v = pos[23:16];
         ccr_pkg::ADR_FS_LO:     v = s.fs_code[7:0];
         ccr_pkg::ADR_FS_HI:     v = s.fs_code[15:8];
         ccr_pkg::ADR_PM1:       v = s.pm1;
         ccr_pkg::ADR_PM2:       v = s.pm2;
         ccr_pkg::ADR_PM3:       v = s.pm3;
         ccr_pkg::ADR_PM4:       v = s.pm4;
         ccr_pkg::ADR_TS_CTRL:   v = {6'h00, s.ts_ctrl};
         ccr_pkg::ADR_REFO_CTRL: v = {7'h00, s.refo_en};
         ccr_pkg::ADR_PLL_DIV:   v = s.pll_div;
         default:                v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   ccr_pkg::ccr_state_t st;
   ccr_pkg::ccr_state_t next_st;
   logic                sclk_ok;
   logic                sdi_now;
   logic                sclk_rise;
   logic                sclk_fall;
   logic [23:0]         word;
   logic                wr_now;

   // Pins are filtered: a level counts only once the second and third stages agree.
   assign sclk_ok   = st.sclk_s[1] == st.sclk_s[2];
   assign sdi_now   = (st.sdi_s[1] == st.sdi_s[2]) ? st.sdi_s[2] : st.sdi_f;
   assign sclk_rise = sclk_ok && st.sclk_s[2] && !st.sclk_f && !st.csn_f;
   assign sclk_fall = sclk_ok && !st.sclk_s[2] && st.sclk_f && !st.csn_f;
   assign word      = {st.shin[22:0], sdi_now};
   assign wr_now    = sclk_rise && (st.cnt == ccr_pkg::CNT_LAST) && !st.reading;

   always_comb begin
      next_st        = st;
      next_st.sclk_s = {st.sclk_s[1:0], SCLK};
      next_st.sdi_s  = {st.sdi_s[1:0], SDI};
      next_st.csn_s  = {st.csn_s[1:0], CSN};
      if (sclk_ok) begin
         next_st.sclk_f = st.sclk_s[2];
      end
      next_st.sdi_f = sdi_now;
      if (st.csn_s[1] == st.csn_s[2]) begin
         next_st.csn_f = st.csn_s[2];
      end

      // ------------------------------------------------------------
      // Serial frame: R/W bit, 15 address bits, 8 data bits, MSB first
      // ------------------------------------------------------------
      if (st.csn_f) begin
         next_st.cnt     = 5'h00;
         next_st.reading = 1'b0;
         next_st.sdo_oe  = 1'b0;
         next_st.sdo     = 1'b0;
      end else begin
         if (sclk_rise && st.cnt != ccr_pkg::CNT_DONE) begin
            next_st.shin = word;
            next_st.cnt  = st.cnt + 5'h01;
            if (st.cnt == ccr_pkg::CNT_ADDR) begin
               next_st.reading = word[ccr_pkg::ADDR_W];
               next_st.sdout   = ccr_read(word[14:0], st, REFERENCE_EDGE_POSITION);
            end
         end
         // Data changes on the falling edge so it is stable at the host's next rising edge.
         if (sclk_fall && st.reading && st.cnt >= ccr_pkg::CNT_DATA0) begin
            next_st.sdo    = st.sdout[7];
            next_st.sdout  = {st.sdout[6:0], 1'b0};
            next_st.sdo_oe = 1'b1;
         end
      end

      // ------------------------------------------------------------
      // Register writes, taken on the last bit of a write frame
      // ------------------------------------------------------------
      if (wr_now) begin
         unique case (word[22:8])
            ccr_pkg::ADR_ALIGN_SEL: next_st.align_sel = word[3:0];
            ccr_pkg::ADR_FS_LO:     next_st.fs_code[7:0] = word[7:0];
            ccr_pkg::ADR_FS_HI:     next_st.fs_code[15:8] = word[7:0];
            ccr_pkg::ADR_PM1:       next_st.pm1 = word[7:0];
            ccr_pkg::ADR_PM2:       next_st.pm2 = word[7:0];
            ccr_pkg::ADR_PM3:       next_st.pm3 = word[7:0];
            ccr_pkg::ADR_PM4:       next_st.pm4 = word[7:0];
            ccr_pkg::ADR_TS_CTRL:   next_st.ts_ctrl = word[1:0];
            ccr_pkg::ADR_REFO_CTRL: next_st.refo_en = word[ccr_pkg::REFO_EN_BIT];
            ccr_pkg::ADR_PLL_DIV:   next_st.pll_div = word[7:0];
            default:                next_st.pll_div = st.pll_div;
         endcase
      end

      // Reserved power codes are kept as written; only a reserved code in pm1 is flagged to the core.
      next_st.pm_reserved   = !(st.pm1 == ccr_pkg::PM_LOW_POWER || st.pm1 == ccr_pkg::PM_HIGH_PERF);
      next_st.refclk_active = st.refo_en && PLL_ENABLE;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st           <= '0;
         st.sclk_f    <= 1'b0;
         st.csn_s     <= 3'h7;
         st.csn_f     <= 1'b1;
         st.align_sel <= ccr_pkg::RST_ALIGN;
         st.fs_code   <= ccr_pkg::RST_FS;
         st.pm1       <= ccr_pkg::RST_PM;
         st.pm2       <= ccr_pkg::RST_PM;
         st.pm3       <= ccr_pkg::RST_PM;
         st.pm4       <= ccr_pkg::RST_PM;
         st.ts_ctrl   <= ccr_pkg::RST_TS;
         st.refo_en   <= ccr_pkg::RST_REFO_EN;
         st.pll_div   <= ccr_pkg::RST_PLL_DIV;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign SDO                           = st.sdo;
   assign SDO_OE                        = st.sdo_oe;
   assign ALIGNMENT_DELAY_SELECT        = st.align_sel;
   assign FULL_SCALE_CODE               = st.fs_code;
   assign POWER_MODE_CODE               = st.pm1;
   assign POWER_MODE_SECOND             = st.pm2;
   assign POWER_MODE_THIRD              = st.pm3;
   assign POWER_MODE_FOURTH             = st.pm4;
   assign POWER_MODE_RESERVED           = st.pm_reserved;
   assign TIMESTAMP_RECEIVER_ENABLE     = st.ts_ctrl[ccr_pkg::TS_RECV_BIT];
   assign TIMESTAMP_PECL_MODE           = st.ts_ctrl[ccr_pkg::TS_PECL_BIT];
   assign PLL_FEEDBACK_DIVIDER          = st.pll_div;
   assign REFERENCE_CLOCK_OUTPUT_ACTIVE = st.refclk_active;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   property p_pos_read;
      (sclk_rise && st.cnt == ccr_pkg::CNT_ADDR && word[14:0] == ccr_pkg::ADR_POS_MID)
         |=> st.sdout == $past(REFERENCE_EDGE_POSITION[15:8]);
   endproperty
   a_pos_read: assert property (p_pos_read) else $error("position byte not loaded for read");

   property p_fs_write;
      (wr_now && word[22:8] == ccr_pkg::ADR_FS_HI)
         |=> FULL_SCALE_CODE[15:8] == $past(word[7:0]) && $stable(FULL_SCALE_CODE[7:0]);
   endproperty
   a_fs_write: assert property (p_fs_write) else $error("full-scale high byte write lost");

   property p_pm_flag;
      !(POWER_MODE_CODE == ccr_pkg::PM_LOW_POWER || POWER_MODE_CODE == ccr_pkg::PM_HIGH_PERF)
         |-> ##1 POWER_MODE_RESERVED;
   endproperty
   a_pm_flag: assert property (p_pm_flag) else $error("reserved power code not flagged");

   property p_pm_legal;
      (POWER_MODE_CODE == ccr_pkg::PM_LOW_POWER) [*2] |-> !POWER_MODE_RESERVED;
   endproperty
   a_pm_legal: assert property (p_pm_legal) else $error("legal power code flagged reserved");

   property p_ts_enable;
      (wr_now && word[22:8] == ccr_pkg::ADR_TS_CTRL) |=> TIMESTAMP_RECEIVER_ENABLE == $past(word[0]);
   endproperty
   a_ts_enable: assert property (p_ts_enable) else $error("timestamp enable not written");

   property p_ts_pecl;
      (wr_now && word[22:8] == ccr_pkg::ADR_TS_CTRL) |=> TIMESTAMP_PECL_MODE == $past(word[1]);
   endproperty
   a_ts_pecl: assert property (p_ts_pecl) else $error("timestamp PECL mode not written");

   property p_refclk;
      (st.refo_en && PLL_ENABLE) |=> REFERENCE_CLOCK_OUTPUT_ACTIVE;
   endproperty
   a_refclk: assert property (p_refclk) else $error("reference clock output not active");

   property p_refclk_off;
      !PLL_ENABLE |=> !REFERENCE_CLOCK_OUTPUT_ACTIVE;
   endproperty
   a_refclk_off: assert property (p_refclk_off) else $error("reference clock active without PLL");

   property p_align;
      (wr_now && word[22:8] == ccr_pkg::ADR_ALIGN_SEL) |=> ALIGNMENT_DELAY_SELECT == $past(word[3:0]);
   endproperty
   a_align: assert property (p_align) else $error("alignment delay select not written");

   property p_oe_frame;
      SDO_OE |-> !st.csn_f || $past(!st.csn_f);
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("SDO driven outside a frame");

   c_write_pm: cover property (wr_now && word[22:8] == ccr_pkg::ADR_PM1);
   // At the sixteenth rise only the low 16 bits of the word hold this frame's command and address.
   c_read_pos: cover property (sclk_rise && st.cnt == ccr_pkg::CNT_ADDR && word[ccr_pkg::ADDR_W]
                               && word[14:0] == ccr_pkg::ADR_POS_LO);
   c_low_power: cover property (POWER_MODE_CODE == ccr_pkg::PM_LOW_POWER);
   c_refclk_on: cover property ($rose(REFERENCE_CLOCK_OUTPUT_ACTIVE));

endmodule
